// ### hw/audio_adc_page0_register_bank.sv
`timescale 1ns/10ps
`include "audio_adc_page0_map.svh"

module audio_adc_page0_register_bank #(
  // Serial bus address; the value is arbitrary
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Two-wire serial control bus, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Monitor values and configuration to the device core
  input audio_adc_page0_pkg::monitor_in_s monitor,
  output audio_adc_page0_pkg::config_out_s config_out
);

  localparam logic [16:0] REG_TABLE [`REG_COUNT] = '{
    `REG_PAGE_SELECT, `REG_SOFT_RESET_CTL, `REG_SLEEP_CTL, `REG_SHUTDOWN_CTL,
    `REG_SERIAL_AUDIO_CFG_A, `REG_SERIAL_AUDIO_CFG_B, `REG_SERIAL_AUDIO_CFG_C,
    `REG_SERIAL_INPUT_MIXING, `REG_CHAN1_SLOT_ASSIGN, `REG_CHAN2_SLOT_ASSIGN,
    `REG_CHAN3_SLOT_ASSIGN, `REG_CHAN4_SLOT_ASSIGN, `REG_BUS_CONTROLLER_CFG_A,
    `REG_BUS_CONTROLLER_CFG_B, `REG_BUS_CLOCK_MONITOR, `REG_CLOCK_SOURCE_SEL,
    `REG_DENSITY_CLOCK_GEN, `REG_DENSITY_INPUT_EDGE, `REG_GENERAL_PIN_CFG,
    `REG_GENERAL_OUTPUT_CFG, `REG_GENERAL_OUTPUT_VALUE, `REG_GENERAL_PIN_MONITOR,
    `REG_GENERAL_INPUT_CFG, `REG_GENERAL_INPUT_MONITOR, `REG_INTERRUPT_CFG,
    `REG_INTERRUPT_MASK_A, `REG_INTERRUPT_LATCHED_A, `REG_COMMON_MODE_TOLERANCE,
    `REG_BIAS_CONVERTER_CFG, `REG_CHAN1_SETUP_A, `REG_CHAN1_SETUP_B,
    `REG_CHAN1_SETUP_C, `REG_CHAN1_SETUP_D, `REG_CHAN1_SETUP_E, `REG_CHAN2_SETUP_A,
    `REG_CHAN2_SETUP_B, `REG_CHAN2_SETUP_C, `REG_CHAN2_SETUP_D, `REG_CHAN2_SETUP_E,
    `REG_CHAN3_SETUP_C, `REG_CHAN3_SETUP_D, `REG_CHAN3_SETUP_E, `REG_CHAN4_SETUP_C,
    `REG_CHAN4_SETUP_D, `REG_CHAN4_SETUP_E, `REG_PROCESSING_CFG_A,
    `REG_PROCESSING_CFG_B, `REG_RANGE_ENHANCER_CFG, `REG_INPUT_CHANNEL_ENABLES
  };

  function automatic logic [6:0] off_of(input logic [16:0] entry);
    return entry[14:8];
  endfunction : off_of

  function automatic logic [1:0] acc_of(input int off);
    logic [1:0] acc;
    acc = `ACC_NONE;
    for (int k = 0; k < `REG_COUNT; k++)
    begin
      if (int'(REG_TABLE[k][14:8]) == off)
      begin
        acc = REG_TABLE[k][16:15];
      end
    end
    return acc;
  endfunction : acc_of

  // Unmapped offsets stay zero so they read as zero
  function automatic logic [127:0][7:0] build_defaults();
    logic [127:0][7:0] d;
    d = '0;
    for (int k = 0; k < `REG_COUNT; k++)
    begin
      d[REG_TABLE[k][14:8]] = REG_TABLE[k][7:0];
    end
    return d;
  endfunction : build_defaults

  localparam logic [127:0][7:0] DEFAULTS = build_defaults();
  localparam logic [6:0] PAGE_OFF = off_of(`REG_PAGE_SELECT);
  localparam logic [6:0] SRST_OFF = off_of(`REG_SOFT_RESET_CTL);
  localparam logic [6:0] SLEEP_OFF = off_of(`REG_SLEEP_CTL);
  localparam logic [6:0] MASK_OFF = off_of(`REG_INTERRUPT_MASK_A);
  localparam logic [6:0] CHEN_OFF = off_of(`REG_INPUT_CHANNEL_ENABLES);
  localparam logic [6:0] BCM_OFF = off_of(`REG_BUS_CLOCK_MONITOR);
  localparam logic [6:0] GPM_OFF = off_of(`REG_GENERAL_PIN_MONITOR);
  localparam logic [6:0] GIM_OFF = off_of(`REG_GENERAL_INPUT_MONITOR);
  localparam logic [6:0] ILT_OFF = off_of(`REG_INTERRUPT_LATCHED_A);

  audio_adc_page0_pkg::bank_state_s s_reg;
  audio_adc_page0_pkg::bank_state_s s_next;
  logic [`PAGE_OFFSETS-1:0][1:0] acc_map;
  logic page_ok;
  logic [7:0] rd_data;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  for (genvar i = 0; i < `PAGE_OFFSETS; i++)
  begin : g_access
    localparam logic [1:0] ACC = acc_of(i);
    assign acc_map[i] = ACC;
  end

  // Offset zero is the page register on every page
  assign page_ok = (s_reg.ptr == PAGE_OFF) || (s_reg.regs[PAGE_OFF] == `CONFIG_PAGE);
  // Self-clearing reset register and unmapped offsets read zero
  assign rd_data = (page_ok && (acc_map[s_reg.ptr] == `ACC_RW ||
                    acc_map[s_reg.ptr] == `ACC_RO)) ? s_reg.regs[s_reg.ptr] : 8'h00;

  assign scl_rise = scl_in && !s_reg.scl_q;
  assign scl_fall = !scl_in && s_reg.scl_q;
  assign start_cond = scl_in && s_reg.scl_q && s_reg.sda_q && !sda_in;
  assign stop_cond = scl_in && s_reg.scl_q && !s_reg.sda_q && sda_in;

  always_comb
  begin
    s_next = s_reg;
    s_next.scl_q = scl_in;
    s_next.sda_q = sda_in;
    if (s_reg.sw_rst_pend)
    begin
      // Whole bank back to defaults, page zero included
      s_next.regs = DEFAULTS;
      s_next.sw_rst_pend = 1'b0;
    end
    else
    begin
      s_next.regs[BCM_OFF] = monitor.bus_clock_monitor;
      s_next.regs[GPM_OFF] = monitor.general_pin_monitor;
      s_next.regs[GIM_OFF] = monitor.general_input_monitor;
      s_next.regs[ILT_OFF] = monitor.interrupt_latched_a;
    end
    if (start_cond)
    begin
      // Repeated start keeps the offset pointer for the read that follows
      s_next.st = audio_adc_page0_pkg::SER_ADDR;
      s_next.bit_cnt = 4'h0;
      s_next.drive_low = 1'b0;
    end
    else if (stop_cond)
    begin
      s_next.st = audio_adc_page0_pkg::SER_IDLE;
      s_next.drive_low = 1'b0;
    end
    else
    begin
      unique case (s_reg.st)
        audio_adc_page0_pkg::SER_IDLE:
        begin
          s_next.drive_low = 1'b0;
        end
        audio_adc_page0_pkg::SER_ADDR,
        audio_adc_page0_pkg::SER_OFFSET,
        audio_adc_page0_pkg::SER_WDATA:
        begin
          if (scl_rise && s_reg.bit_cnt != `BYTE_BITS)
          begin
            s_next.shreg = {s_reg.shreg[6:0], sda_in};
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          end
          else if (scl_fall && s_reg.bit_cnt == `BYTE_BITS)
          begin
            s_next.bit_cnt = 4'h0;
            s_next.drive_low = 1'b1;
            if (s_reg.st == audio_adc_page0_pkg::SER_ADDR)
            begin
              if (s_reg.shreg[7:1] == DEV_ADDR)
              begin
                s_next.rw = s_reg.shreg[0];
                s_next.st = audio_adc_page0_pkg::SER_ADDR_ACK;
              end
              else
              begin
                // Not our address: stay off the bus until the next start
                s_next.drive_low = 1'b0;
                s_next.st = audio_adc_page0_pkg::SER_IDLE;
              end
            end
            else if (s_reg.st == audio_adc_page0_pkg::SER_OFFSET)
            begin
              s_next.ptr = s_reg.shreg[6:0];
              s_next.st = audio_adc_page0_pkg::SER_OFFSET_ACK;
            end
            else
            begin
              if (s_reg.ptr == PAGE_OFF)
              begin
                s_next.regs[PAGE_OFF] = s_reg.shreg;
              end
              else if (page_ok && s_reg.ptr == SRST_OFF)
              begin
                // Only the reset bit acts; upper bits are never stored
                if (s_reg.shreg[`SOFT_RESET_BIT])
                begin
                  s_next.sw_rst_pend = 1'b1;
                end
              end
              else if (page_ok && acc_map[s_reg.ptr] == `ACC_RW)
              begin
                s_next.regs[s_reg.ptr] = s_reg.shreg;
              end
              // Burst writes walk through consecutive offsets
              s_next.ptr = s_reg.ptr + 7'h01;
              s_next.st = audio_adc_page0_pkg::SER_WDATA_ACK;
            end
          end
        end
        audio_adc_page0_pkg::SER_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            s_next.bit_cnt = 4'h0;
            if (s_reg.rw)
            begin
              s_next.shreg = rd_data;
              s_next.ptr = s_reg.ptr + 7'h01;
              s_next.drive_low = !rd_data[7];
              s_next.st = audio_adc_page0_pkg::SER_RDATA;
            end
            else
            begin
              s_next.drive_low = 1'b0;
              s_next.st = audio_adc_page0_pkg::SER_OFFSET;
            end
          end
        end
        audio_adc_page0_pkg::SER_OFFSET_ACK,
        audio_adc_page0_pkg::SER_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            s_next.bit_cnt = 4'h0;
            s_next.drive_low = 1'b0;
            s_next.st = audio_adc_page0_pkg::SER_WDATA;
          end
        end
        audio_adc_page0_pkg::SER_RDATA:
        begin
          if (scl_fall)
          begin
            if (s_reg.bit_cnt == `LAST_BIT)
            begin
              s_next.drive_low = 1'b0;
              s_next.st = audio_adc_page0_pkg::SER_HOST_ACK;
            end
            else
            begin
              s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
              s_next.shreg = {s_reg.shreg[6:0], 1'b0};
              s_next.drive_low = !s_reg.shreg[6];
            end
          end
        end
        audio_adc_page0_pkg::SER_HOST_ACK:
        begin
          if (scl_rise)
          begin
            s_next.host_acked = !sda_in;
          end
          else if (scl_fall)
          begin
            s_next.bit_cnt = 4'h0;
            if (s_reg.host_acked)
            begin
              s_next.shreg = rd_data;
              s_next.ptr = s_reg.ptr + 7'h01;
              s_next.drive_low = !rd_data[7];
              s_next.st = audio_adc_page0_pkg::SER_RDATA;
            end
            else
            begin
              s_next.st = audio_adc_page0_pkg::SER_IDLE;
            end
          end
        end
        default:
        begin
          s_next.drive_low = 1'b0;
          s_next.st = audio_adc_page0_pkg::SER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_reg.regs <= DEFAULTS;
      s_reg.st <= audio_adc_page0_pkg::SER_IDLE;
      s_reg.bit_cnt <= 4'h0;
      s_reg.shreg <= 8'h00;
      s_reg.ptr <= 7'h00;
      s_reg.rw <= 1'b0;
      s_reg.scl_q <= 1'b1;
      s_reg.sda_q <= 1'b1;
      s_reg.drive_low <= 1'b0;
      s_reg.host_acked <= 1'b0;
      s_reg.sw_rst_pend <= 1'b0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe = s_reg.drive_low;
  assign config_out.page_select = s_reg.regs[PAGE_OFF];
  assign config_out.sleep_ctl = s_reg.regs[SLEEP_OFF];
  assign config_out.interrupt_mask_a = s_reg.regs[MASK_OFF];
  assign config_out.input_channel_enables = s_reg.regs[CHEN_OFF];
  assign config_out.soft_reset_pulse = s_reg.sw_rst_pend;

endmodule : audio_adc_page0_register_bank

// ### pkg/audio_adc_page0_map.svh
`ifndef AUDIO_ADC_PAGE0_MAP_SVH
`define AUDIO_ADC_PAGE0_MAP_SVH

// Access classes held in each register table entry
`define ACC_RW 2'h0
`define ACC_RO 2'h1
`define ACC_SC 2'h2
`define ACC_NONE 2'h3

// Page geometry and serial byte framing
`define PAGE_OFFSETS 128
`define CONFIG_PAGE 8'h00
`define BYTE_BITS 4'h8
`define LAST_BIT 4'h7
`define SOFT_RESET_BIT 0

// Register table entries: {access, offset, reset value}
`define REG_COUNT 49
`define REG_PAGE_SELECT {`ACC_RW, 7'h00, 8'h00}
`define REG_SOFT_RESET_CTL {`ACC_SC, 7'h01, 8'h00}
`define REG_SLEEP_CTL {`ACC_RW, 7'h02, 8'h00}
`define REG_SHUTDOWN_CTL {`ACC_RW, 7'h05, 8'h05}
`define REG_SERIAL_AUDIO_CFG_A {`ACC_RW, 7'h07, 8'h30}
`define REG_SERIAL_AUDIO_CFG_B {`ACC_RW, 7'h08, 8'h00}
`define REG_SERIAL_AUDIO_CFG_C {`ACC_RW, 7'h09, 8'h00}
`define REG_SERIAL_INPUT_MIXING {`ACC_RW, 7'h0A, 8'h00}
`define REG_CHAN1_SLOT_ASSIGN {`ACC_RW, 7'h0B, 8'h00}
`define REG_CHAN2_SLOT_ASSIGN {`ACC_RW, 7'h0C, 8'h01}
`define REG_CHAN3_SLOT_ASSIGN {`ACC_RW, 7'h0D, 8'h02}
`define REG_CHAN4_SLOT_ASSIGN {`ACC_RW, 7'h0E, 8'h03}
`define REG_BUS_CONTROLLER_CFG_A {`ACC_RW, 7'h13, 8'h02}
`define REG_BUS_CONTROLLER_CFG_B {`ACC_RW, 7'h14, 8'h48}
`define REG_BUS_CLOCK_MONITOR {`ACC_RO, 7'h15, 8'hFF}
`define REG_CLOCK_SOURCE_SEL {`ACC_RW, 7'h16, 8'h10}
`define REG_DENSITY_CLOCK_GEN {`ACC_RW, 7'h1F, 8'h40}
`define REG_DENSITY_INPUT_EDGE {`ACC_RW, 7'h20, 8'h00}
`define REG_GENERAL_PIN_CFG {`ACC_RW, 7'h21, 8'h22}
`define REG_GENERAL_OUTPUT_CFG {`ACC_RW, 7'h22, 8'h00}
`define REG_GENERAL_OUTPUT_VALUE {`ACC_RW, 7'h29, 8'h00}
`define REG_GENERAL_PIN_MONITOR {`ACC_RO, 7'h2A, 8'h00}
`define REG_GENERAL_INPUT_CFG {`ACC_RW, 7'h2B, 8'h00}
`define REG_GENERAL_INPUT_MONITOR {`ACC_RO, 7'h2F, 8'h00}
`define REG_INTERRUPT_CFG {`ACC_RW, 7'h32, 8'h00}
`define REG_INTERRUPT_MASK_A {`ACC_RW, 7'h33, 8'hFF}
`define REG_INTERRUPT_LATCHED_A {`ACC_RO, 7'h36, 8'h00}
`define REG_COMMON_MODE_TOLERANCE {`ACC_RW, 7'h3A, 8'h00}
`define REG_BIAS_CONVERTER_CFG {`ACC_RW, 7'h3B, 8'h00}
`define REG_CHAN1_SETUP_A {`ACC_RW, 7'h3C, 8'h00}
`define REG_CHAN1_SETUP_B {`ACC_RW, 7'h3D, 8'h00}
`define REG_CHAN1_SETUP_C {`ACC_RW, 7'h3E, 8'hC9}
`define REG_CHAN1_SETUP_D {`ACC_RW, 7'h3F, 8'h80}
`define REG_CHAN1_SETUP_E {`ACC_RW, 7'h40, 8'h00}
`define REG_CHAN2_SETUP_A {`ACC_RW, 7'h41, 8'h00}
`define REG_CHAN2_SETUP_B {`ACC_RW, 7'h42, 8'h00}
`define REG_CHAN2_SETUP_C {`ACC_RW, 7'h43, 8'hC9}
`define REG_CHAN2_SETUP_D {`ACC_RW, 7'h44, 8'h80}
`define REG_CHAN2_SETUP_E {`ACC_RW, 7'h45, 8'h00}
`define REG_CHAN3_SETUP_C {`ACC_RW, 7'h48, 8'hC9}
`define REG_CHAN3_SETUP_D {`ACC_RW, 7'h49, 8'h80}
`define REG_CHAN3_SETUP_E {`ACC_RW, 7'h4A, 8'h00}
`define REG_CHAN4_SETUP_C {`ACC_RW, 7'h4D, 8'hC9}
`define REG_CHAN4_SETUP_D {`ACC_RW, 7'h4E, 8'h80}
`define REG_CHAN4_SETUP_E {`ACC_RW, 7'h4F, 8'h00}
`define REG_PROCESSING_CFG_A {`ACC_RW, 7'h6B, 8'h01}
`define REG_PROCESSING_CFG_B {`ACC_RW, 7'h6C, 8'h40}
`define REG_RANGE_ENHANCER_CFG {`ACC_RW, 7'h6D, 8'h7B}
`define REG_INPUT_CHANNEL_ENABLES {`ACC_RW, 7'h73, 8'hC0}

`endif

// ### pkg/audio_adc_page0_pkg.sv
package audio_adc_page0_pkg;

  typedef enum logic [3:0] {
    SER_IDLE = 4'b0000,
    SER_ADDR = 4'b0001,
    SER_ADDR_ACK = 4'b0010,
    SER_OFFSET = 4'b0011,
    SER_OFFSET_ACK = 4'b0100,
    SER_WDATA = 4'b0101,
    SER_WDATA_ACK = 4'b0110,
    SER_RDATA = 4'b0111,
    SER_HOST_ACK = 4'b1000
  } serial_state_e;

  // Values shown by the read-only monitor registers
  typedef struct packed {
    logic [7:0] bus_clock_monitor;
    logic [7:0] general_pin_monitor;
    logic [7:0] general_input_monitor;
    logic [7:0] interrupt_latched_a;
  } monitor_in_s;

  // Settings handed to the rest of the device
  typedef struct packed {
    logic [7:0] page_select;
    logic [7:0] sleep_ctl;
    logic [7:0] interrupt_mask_a;
    logic [7:0] input_channel_enables;
    logic soft_reset_pulse;
  } config_out_s;

  typedef struct packed {
    logic [127:0][7:0] regs;
    serial_state_e st;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [6:0] ptr;
    logic rw;
    logic scl_q;
    logic sda_q;
    logic drive_low;
    logic host_acked;
    logic sw_rst_pend;
  } bank_state_s;

endpackage : audio_adc_page0_pkg

// ### verification/audio_adc_page0_register_bank_props.sv
`timescale 1ns/10ps

module audio_adc_page0_register_bank_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Device core side
  input audio_adc_page0_pkg::monitor_in_s monitor,
  input audio_adc_page0_pkg::config_out_s config_out
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  chk_reset_mask: assert property ($fell(reset) |-> config_out.interrupt_mask_a == 8'hFF)
    else $error("mask not all ones after reset");
  chk_reset_enables: assert property ($fell(reset) |-> config_out.input_channel_enables == 8'hC0)
    else $error("channel enables wrong after reset");
  chk_reset_page: assert property ($fell(reset) |-> config_out.page_select == 8'h00)
    else $error("page not zero after reset");
  chk_sreset_defaults: assert property (config_out.soft_reset_pulse |-> ##[1:2]
    (config_out.interrupt_mask_a == 8'hFF && config_out.input_channel_enables == 8'hC0
    && config_out.sleep_ctl == 8'h00))
    else $error("defaults not restored by soft reset");
  chk_sreset_page: assert property (config_out.soft_reset_pulse |-> ##[1:2]
    config_out.page_select == 8'h00)
    else $error("page not zero after soft reset");
  chk_sreset_once: assert property (config_out.soft_reset_pulse |=> !config_out.soft_reset_pulse [*8])
    else $error("soft reset did not clear itself");
  // A page change outside reset only happens while a written byte is acknowledged
  chk_page_by_write: assert property ($changed(config_out.page_select) && !$past(reset)
    && !$past(reset, 2) |-> ##[0:1] (sda_oe || $past(sda_oe)))
    else $error("page changed without a write");
  chk_mask_by_write: assert property ($changed(config_out.interrupt_mask_a) && !$past(reset)
    && !$past(reset, 2) |-> ##[0:1] (sda_oe || $past(sda_oe)))
    else $error("mask changed without a write");

  cover property (config_out.soft_reset_pulse);
  cover property ($rose(sda_oe));
  cover property (config_out.page_select == 8'hFF);
endmodule : audio_adc_page0_register_bank_props

bind audio_adc_page0_register_bank audio_adc_page0_register_bank_props i_props (
  .mclk(mclk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .monitor(monitor), .config_out(config_out));

// ### verification/serial_host_model.sv
`timescale 1ns/10ps

module serial_host_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  // Clock and resolved data wire
  input wire logic mclk,
  input wire logic sda_wire,
  // Host drive, sda_pull high pulls the wire low
  output logic scl,
  output logic sda_pull,
  output logic [7:0] nacks
);
  logic r;

  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
    nacks = 8'h00;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge mclk);
  endtask : gap

  // Four cycles each side of SCL leave the device its three-cycle setup margin
  task automatic clk_bit(input logic b, output logic v);
    sda_pull = !b;
    gap(4);
    scl = 1'b1;
    gap(2);
    v = sda_wire;
    gap(2);
    scl = 1'b0;
    gap(1);
  endtask : clk_bit

  task automatic start;
    sda_pull = 1'b0;
    gap(4);
    scl = 1'b1;
    gap(4);
    sda_pull = 1'b1;
    gap(4);
    scl = 1'b0;
    gap(4);
  endtask : start

  task automatic stop;
    sda_pull = 1'b1;
    gap(4);
    scl = 1'b1;
    gap(4);
    sda_pull = 1'b0;
    gap(4);
  endtask : stop

  task automatic send(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      clk_bit(v[i], r);
    clk_bit(1'b1, r);
    if (r !== 1'b0)
      nacks = nacks + 8'h01;
  endtask : send

  // Offsets come only from the mapped list; page changes go through offset zero
  task automatic wr(input logic [7:0] off, input int n, input logic [7:0] d [0:3]);
    start();
    send({ADDR, 1'b0});
    send(off);
    for (int i = 0; i < n; i++)
      send(d[i]);
    stop();
  endtask : wr

  task automatic rd(input logic [7:0] off, input int n, output logic [7:0] q [0:3]);
    start();
    send({ADDR, 1'b0});
    send(off);
    start();
    send({ADDR, 1'b1});
    for (int i = 0; i < n; i++)
    begin
      for (int b = 7; b >= 0; b--)
        clk_bit(1'b1, q[i][b]);
      clk_bit(i == n - 1, r);
    end
    stop();
  endtask : rd
endmodule : serial_host_model

// ### verification/audio_adc_page0_register_bank_test.sv
`timescale 1ns/10ps

module audio_adc_page0_register_bank_test;
  logic mclk;
  logic reset;
  logic scl;
  logic sda_pull;
  logic sda_w;
  logic sda_out;
  logic sda_oe;
  logic [7:0] nacks;
  logic [7:0] q [0:3];
  logic [7:0] d [0:3];
  audio_adc_page0_pkg::monitor_in_s mon;
  audio_adc_page0_pkg::config_out_s cfg;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;

  // Open drain: either party pulling makes the wire low
  assign sda_w = !((sda_oe && !sda_out) || sda_pull);

  audio_adc_page0_register_bank #(.DEV_ADDR(7'h2A)) i_audio_adc_page0_register_bank (
    .mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .monitor(mon), .config_out(cfg));

  serial_host_model #(.ADDR(7'h2A)) i_serial_host_model (
    .mclk(mclk), .sda_wire(sda_w), .scl(scl), .sda_pull(sda_pull), .nacks(nacks));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = !mclk;
  end

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  // Every test finishes in under two thousand cycles; the ceiling leaves ample slack
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      fails = fails + 1;
      conclude();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_defaults;
    check(cfg.interrupt_mask_a, 8'hFF);
    check(cfg.input_channel_enables, 8'hC0);
    check(cfg.page_select, 8'h00);
    check(cfg.sleep_ctl, 8'h00);
    i_serial_host_model.rd(8'h3E, 3, q);
    check(q[0], 8'hC9);
    check(q[1], 8'h80);
    check(q[2], 8'h00);
    i_serial_host_model.rd(8'h14, 2, q);
    check(q[0], 8'h48);
    check(q[1], 8'h96);
    i_serial_host_model.rd(8'h73, 1, q);
    check(q[0], 8'hC0);
    check(nacks, 8'h00);
    $display("test defaults done");
  endtask : test_defaults

  task automatic test_write;
    d = '{8'h5A, 8'h00, 8'h00, 8'h00};
    i_serial_host_model.wr(8'h33, 1, d);
    check(cfg.interrupt_mask_a, 8'h5A);
    d = '{8'hA1, 8'hB2, 8'hC3, 8'h00};
    i_serial_host_model.wr(8'h0B, 3, d);
    i_serial_host_model.rd(8'h0B, 4, q);
    check(q[0], 8'hA1);
    check(q[1], 8'hB2);
    check(q[2], 8'hC3);
    check(q[3], 8'h03);
    d = '{8'h81, 8'h00, 8'h00, 8'h00};
    i_serial_host_model.wr(8'h02, 1, d);
    check(cfg.sleep_ctl, 8'h81);
    check(nacks, 8'h00);
    $display("test write done");
  endtask : test_write

  task automatic test_soft_reset;
    d = '{8'h01, 8'h00, 8'h00, 8'h00};
    i_serial_host_model.wr(8'h01, 1, d);
    check(cfg.interrupt_mask_a, 8'hFF);
    check(cfg.sleep_ctl, 8'h00);
    check(cfg.page_select, 8'h00);
    check(cfg.soft_reset_pulse, 1'b0);
    i_serial_host_model.rd(8'h01, 1, q);
    check(q[0], 8'h00);
    i_serial_host_model.rd(8'h0B, 2, q);
    check(q[0], 8'h00);
    check(q[1], 8'h01);
    check(nacks, 8'h00);
    $display("test soft reset done");
  endtask : test_soft_reset

  task automatic test_pages;
    d = '{8'h03, 8'h00, 8'h00, 8'h00};
    i_serial_host_model.wr(8'h00, 1, d);
    check(cfg.page_select, 8'h03);
    i_serial_host_model.rd(8'h33, 1, q);
    check(q[0], 8'h00);
    d[0] = 8'hFF;
    i_serial_host_model.wr(8'h00, 1, d);
    check(cfg.page_select, 8'hFF);
    d[0] = 8'h00;
    i_serial_host_model.wr(8'h00, 1, d);
    check(cfg.page_select, 8'h00);
    i_serial_host_model.rd(8'h33, 1, q);
    check(q[0], 8'hFF);
    check(nacks, 8'h00);
    $display("test pages done");
  endtask : test_pages

  initial
  begin
    reset = 1'b1;
    mon = {8'h96, 8'h3C, 8'h5A, 8'h0F};
    repeat (10) @(negedge mclk);
    reset = 1'b0;
    repeat (3) @(negedge mclk);
    test_defaults();
    test_write();
    test_soft_reset();
    test_pages();
    conclude();
  end
endmodule : audio_adc_page0_register_bank_test
